// *** hw/prbu_pkg.sv ***
// Package of opcodes, decode types and constants for the branch unit
package prbu_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int PRBU_ADDR_W = 32;
	localparam int PRBU_INSN_W = 16;

	// ----------------------------------------------------------------
	// Opcode fields
	// ----------------------------------------------------------------
	localparam logic [7:0] PRBU_OPC_BOF     = 8'h8B;
	localparam logic [7:0] PRBU_OPC_BOT     = 8'h89;
	localparam logic [7:0] PRBU_OPC_DBOF    = 8'h8F;
	localparam logic [7:0] PRBU_OPC_DBOT    = 8'h8D;
	localparam logic [3:0] PRBU_OPC_DISP    = 4'hA;
	localparam logic [3:0] PRBU_OPC_FAR_HI  = 4'h0;
	localparam logic [7:0] PRBU_OPC_FAR_LO  = 8'h23;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int PRBU_DISP8_MSB  = 7;
	localparam int PRBU_DISP12_MSB = 11;
	localparam int PRBU_REG_LSB    = 8;

	// ----------------------------------------------------------------
	// Address offsets and reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] PRBU_BASE_OFS   = 32'h0000_0004;
	localparam logic [31:0] PRBU_INSN_LEN   = 32'h0000_0002;
	localparam logic [31:0] PRBU_RESET_ADDR = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		PRBU_K_NONE,
		PRBU_K_BOF,
		PRBU_K_BOT,
		PRBU_K_DBOF,
		PRBU_K_DBOT,
		PRBU_K_DISP,
		PRBU_K_FAR
	} prbu_kind_t;

	typedef enum logic {
		PRBU_ST_SEQ,
		PRBU_ST_SLOT
	} prbu_state_t;

	// ----------------------------------------------------------------
	// Decode of the branch group
	// ----------------------------------------------------------------
	function automatic prbu_kind_t prbu_decode(input logic [15:0] insn);
		prbu_kind_t k;
		k = PRBU_K_NONE;
		if (insn[15:8] == PRBU_OPC_BOF) begin
			k = PRBU_K_BOF;
		end else if (insn[15:8] == PRBU_OPC_BOT) begin
			k = PRBU_K_BOT;
		end else if (insn[15:8] == PRBU_OPC_DBOF) begin
			k = PRBU_K_DBOF;
		end else if (insn[15:8] == PRBU_OPC_DBOT) begin
			k = PRBU_K_DBOT;
		end else if (insn[15:12] == PRBU_OPC_DISP) begin
			k = PRBU_K_DISP;
		end else if (insn[15:12] == PRBU_OPC_FAR_HI && insn[7:0] == PRBU_OPC_FAR_LO) begin
			k = PRBU_K_FAR;
		end
		return k;
	endfunction

	function automatic logic prbu_is_delayed(input prbu_kind_t k);
		return (k == PRBU_K_DBOF) || (k == PRBU_K_DBOT) ||
		       (k == PRBU_K_DISP) || (k == PRBU_K_FAR);
	endfunction

endpackage

// *** hw/prbu_target.sv ***
// Branch target adders for the branch unit
`timescale 1ns/10ps
module prbu_target
	import prbu_pkg::*;
(
	// Instruction and its own address
	input  wire logic [15:0] insn,
	input  wire logic [31:0] base_addr,
	// Selected general register contents
	input  wire logic [31:0] reg_value,
	// Targets
	output logic      [31:0] target8,
	output logic      [31:0] target12,
	output logic      [31:0] target_far
);

	logic [31:0] disp8;
	logic [31:0] disp12;
	logic [31:0] base4;

	// Sign-extend, then double
	assign disp8      = {{23{insn[PRBU_DISP8_MSB]}}, insn[PRBU_DISP8_MSB:0], 1'b0};
	assign disp12     = {{19{insn[PRBU_DISP12_MSB]}}, insn[PRBU_DISP12_MSB:0], 1'b0};
	// Base is the branch's own address, never a later fetch
	assign base4      = base_addr + PRBU_BASE_OFS;
	assign target8    = base4 + disp8;
	assign target12   = base4 + disp12;
	assign target_far = base4 + reg_value;

endmodule

// *** hw/prbu_branch_unit.sv ***
// Branch group decode and execute unit with delay-slot sequencing
// Function
// - Conditional target: sext disp8 times two plus four
// - Branch on false: jump if flag 0
// - Branch on true: jump if flag 1
// - Delayed false branch: slot, then conditional jump
// - Slot instruction completes before branch destination
// - No interrupts between delayed branch and slot
// - Branch in delay slot is slot-illegal
// - Delayed false branch in slot is illegal
// - Displacement branch: sext disp12 times two, delayed
// - Far branch: address plus four plus register
// - Target base is the branch's own address
`timescale 1ns/10ps
module prbu_branch_unit
	import prbu_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// Issued instruction
	input  wire logic        insn_valid,
	input  wire logic [15:0] insn,
	input  wire logic [31:0] insn_addr,
	input  wire logic        t_flag,
	input  wire logic [31:0] reg_value,
	input  wire logic        flush,
	// Program counter update
	output logic             insn_done_q,
	output logic             pc_load_q,
	output logic      [31:0] pc_value_q,
	output logic             branch_taken_q,
	// Exception and interrupt control
	output logic             slot_illegal_q,
	output logic      [31:0] slot_illegal_pc_q,
	output logic             int_hold_q
);

	// ----------------------------------------------------------------
	// Decode and targets
	// ----------------------------------------------------------------
	prbu_kind_t  kind;
	logic [31:0] target8;
	logic [31:0] target12;
	logic [31:0] target_far;
	logic [31:0] seq_addr;

	assign kind     = prbu_decode(insn);
	assign seq_addr = insn_addr + PRBU_INSN_LEN;

	prbu_target u_target (
		.insn       (insn),
		.base_addr  (insn_addr),
		.reg_value  (reg_value),
		.target8    (target8),
		.target12   (target12),
		.target_far (target_far)
	);

	// ----------------------------------------------------------------
	// Sequencer state
	// ----------------------------------------------------------------
	prbu_state_t state_q;
	prbu_state_t state_d;
	logic        pend_taken_q;
	logic        pend_taken_d;
	logic [31:0] pend_target_q;
	logic [31:0] pend_target_d;
	logic        done_d;
	logic        load_d;
	logic [31:0] pc_d;
	logic        taken_d;
	logic        ill_d;
	logic [31:0] ill_pc_d;
	logic        hold_d;

	// The flag is never written here; there is no path back to it
	always_comb begin
		state_d       = state_q;
		pend_taken_d  = pend_taken_q;
		pend_target_d = pend_target_q;
		done_d        = 1'b0;
		load_d        = 1'b0;
		pc_d          = pc_value_q;
		taken_d       = 1'b0;
		ill_d         = 1'b0;
		ill_pc_d      = slot_illegal_pc_q;
		if (flush) begin
			// A pending redirect dies with the flushed pair
			state_d      = PRBU_ST_SEQ;
			pend_taken_d = 1'b0;
		end else if (insn_valid) begin
			case (state_q)
				PRBU_ST_SEQ: begin
					done_d = 1'b1;
					pc_d   = seq_addr;
					case (kind)
						PRBU_K_BOF: begin
							if (!t_flag) begin
								load_d  = 1'b1;
								pc_d    = target8;
								taken_d = 1'b1;
							end
						end
						PRBU_K_BOT: begin
							if (t_flag) begin
								load_d  = 1'b1;
								pc_d    = target8;
								taken_d = 1'b1;
							end
						end
						PRBU_K_DBOF: begin
							state_d       = PRBU_ST_SLOT;
							pend_taken_d  = !t_flag;
							pend_target_d = target8;
						end
						PRBU_K_DBOT: begin
							state_d       = PRBU_ST_SLOT;
							pend_taken_d  = t_flag;
							pend_target_d = target8;
						end
						PRBU_K_DISP: begin
							state_d       = PRBU_ST_SLOT;
							pend_taken_d  = 1'b1;
							pend_target_d = target12;
						end
						PRBU_K_FAR: begin
							state_d       = PRBU_ST_SLOT;
							pend_taken_d  = 1'b1;
							pend_target_d = target_far;
						end
						default: begin
						end
					endcase
				end
				PRBU_ST_SLOT: begin
					state_d      = PRBU_ST_SEQ;
					pend_taken_d = 1'b0;
					if (kind != PRBU_K_NONE) begin
						// Any branch here, a delayed false one included
						ill_d    = 1'b1;
						ill_pc_d = insn_addr;
					end else begin
						// Slot retires first, then the destination
						done_d = 1'b1;
						if (pend_taken_q) begin
							load_d  = 1'b1;
							pc_d    = pend_target_q;
							taken_d = 1'b1;
						end else begin
							pc_d = seq_addr;
						end
					end
				end
				default: begin
					state_d = PRBU_ST_SEQ;
				end
			endcase
		end
		// Hold interrupts while a slot is owed to a delayed branch
		hold_d = (state_d == PRBU_ST_SLOT);
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_q           <= PRBU_ST_SEQ;
			pend_taken_q      <= 1'b0;
			pend_target_q     <= PRBU_RESET_ADDR;
			insn_done_q       <= 1'b0;
			pc_load_q         <= 1'b0;
			pc_value_q        <= PRBU_RESET_ADDR;
			branch_taken_q    <= 1'b0;
			slot_illegal_q    <= 1'b0;
			slot_illegal_pc_q <= PRBU_RESET_ADDR;
			int_hold_q        <= 1'b0;
		end else begin
			state_q           <= state_d;
			pend_taken_q      <= pend_taken_d;
			pend_target_q     <= pend_target_d;
			insn_done_q       <= done_d;
			pc_load_q         <= load_d;
			pc_value_q        <= pc_d;
			branch_taken_q    <= taken_d;
			slot_illegal_q    <= ill_d;
			slot_illegal_pc_q <= ill_pc_d;
			int_hold_q        <= hold_d;
		end
	end

endmodule

// *** tb/prbu_regfile_model.sv ***
// Pipeline-side model of the selected general register read
`timescale 1ns/10ps
module prbu_regfile_model (
	// Register select taken from the issued word
	input  wire logic [15:0] insn,
	// Selected register contents
	output logic      [31:0] reg_value
);
	// Upper indexes read as negative values so the far branch also reaches backwards
	assign reg_value = {{20{insn[11]}}, insn[11:8], 8'h00};
endmodule

// *** tb/prbu_properties.sv ***
// Checker of the branch unit retirement timing and targets
`timescale 1ns/10ps
module prbu_properties (
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        rst,
	// Issue port
	input wire logic        insn_valid,
	input wire logic [15:0] insn,
	input wire logic [31:0] insn_addr,
	input wire logic        t_flag,
	input wire logic        flush,
	// Results
	input wire logic        insn_done_q,
	input wire logic        pc_load_q,
	input wire logic [31:0] pc_value_q,
	input wire logic        branch_taken_q,
	input wire logic        slot_illegal_q,
	input wire logic [31:0] slot_illegal_pc_q,
	input wire logic        int_hold_q
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	logic        go;
	logic [31:0] tgt8;
	assign go = insn_valid && !flush;
	assign tgt8 = insn_addr + 32'h0000_0004 + {{23{insn[7]}}, insn[7:0], 1'b0};
	a_taken_load: assert property (branch_taken_q == pc_load_q)
		else $error("taken and load differ");
	a_load_done: assert property (pc_load_q |-> insn_done_q)
		else $error("load without retirement");
	a_issue_answer: assert property (go |=> insn_done_q || slot_illegal_q)
		else $error("issued word not answered in one cycle");
	a_idle_quiet: assert property (!go |=> !insn_done_q && !slot_illegal_q)
		else $error("answer without issue");
	a_false_target: assert property (
		go && !int_hold_q && insn[15:8] == 8'h8B && !t_flag
		|=> pc_load_q && pc_value_q == $past(tgt8))
		else $error("false branch target wrong");
	a_true_fall: assert property (
		go && !int_hold_q && insn[15:8] == 8'h89 && !t_flag
		|=> !pc_load_q && pc_value_q == $past(insn_addr) + 32'h0000_0002)
		else $error("true branch did not fall through");
	a_disp_hold: assert property (
		go && !int_hold_q && insn[15:12] == 4'hA
		|=> int_hold_q && !pc_load_q)
		else $error("no interrupt hold after delayed branch");
	a_slot_illegal: assert property (
		go && int_hold_q && insn[15:12] == 4'hA
		|=> slot_illegal_q && !insn_done_q && slot_illegal_pc_q == $past(insn_addr))
		else $error("branch in slot not refused");
	a_hold_waits: assert property (int_hold_q && !insn_valid && !flush |=> int_hold_q)
		else $error("hold dropped while slot owed");
endmodule
bind prbu_branch_unit prbu_properties chk (.core_clk, .rst, .insn_valid, .insn, .insn_addr,
	.t_flag, .flush, .insn_done_q, .pc_load_q, .pc_value_q, .branch_taken_q, .slot_illegal_q,
	.slot_illegal_pc_q, .int_hold_q);

// *** tb/prbu_branch_unit_bench.sv ***
// Self-checking bench of the branch unit
`timescale 1ns/10ps
module prbu_branch_unit_bench;
	import prbu_pkg::*;
	logic        core_clk, rst, insn_valid, t_flag, flush;
	logic [15:0] insn;
	logic [31:0] insn_addr, reg_value, pc_value_q, slot_illegal_pc_q;
	logic        insn_done_q, pc_load_q, branch_taken_q, slot_illegal_q, int_hold_q;
	int          fails, n_checks;
	prbu_branch_unit dut (.core_clk, .rst, .insn_valid, .insn, .insn_addr, .t_flag, .reg_value,
		.flush, .insn_done_q, .pc_load_q, .pc_value_q, .branch_taken_q, .slot_illegal_q,
		.slot_illegal_pc_q, .int_hold_q);
	prbu_regfile_model regs (.insn, .reg_value);
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task stop_test;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Entered just after an edge, so calls run back to back
	task issue(input logic [15:0] i, input logic [31:0] a, input logic t);
		insn_valid <= 1'b1;
		insn <= i;
		insn_addr <= a;
		t_flag <= t;
		@(posedge core_clk);
		#1;
	endtask
	task idle;
		insn_valid <= 1'b0;
		@(posedge core_clk);
		#1;
	endtask
	task t_cond;
		logic [7:0] op, d;
		logic       tk;
		for (int k = 0; k < 8; k++) begin
			op = k[0] ? 8'h89 : 8'h8B;
			d = k[1] ? 8'h7F : 8'h80;
			tk = (op == 8'h89) == k[2];
			issue({op, d}, 32'h0000_1000, k[2]);
			chk("done", insn_done_q, 1'b1);
			chk("load", pc_load_q, tk);
			chk("taken", branch_taken_q, tk);
			chk("pc", pc_value_q, !tk ? 32'h0000_1002 : d[7] ? 32'h0000_0F04 : 32'h0000_1102);
		end
	endtask
	task t_dly;
		logic [15:0] di[7] = '{16'h8F80, 16'h8F80, 16'h8D7F, 16'h8D7F, 16'hA800, 16'hA7FF, 16'h0923};
		logic        tf[7] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
		logic        ld[7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
		logic [31:0] pc[7] = '{32'h0F04, 32'h1004, 32'h1102, 32'h1004, 32'h0004, 32'h2002, 32'h0904};
		for (int k = 0; k < 7; k++) begin
			issue(di[k], 32'h0000_1000, tf[k]);
			chk("dly load", pc_load_q, 1'b0);
			chk("dly pc", pc_value_q, 32'h0000_1002);
			idle();
			chk("hold", int_hold_q, 1'b1);
			issue(16'h0009, 32'h0000_1002, !tf[k]);
			chk("slot load", pc_load_q, ld[k]);
			chk("slot taken", branch_taken_q, ld[k]);
			chk("slot pc", pc_value_q, pc[k]);
			chk("hold end", int_hold_q, 1'b0);
		end
	endtask
	task t_ill;
		for (int k = 0; k < 2; k++) begin
			issue(16'hA010, 32'h0000_1000, 1'b0);
			issue(k ? 16'h8F80 : 16'h8900, 32'h0000_1002, 1'b0);
			chk("illegal", slot_illegal_q, 1'b1);
			chk("ill done", insn_done_q, 1'b0);
			chk("ill pc", slot_illegal_pc_q, 32'h0000_1002);
			issue(16'h8B02, 32'h0000_1004, 1'b0);
			chk("after pc", pc_value_q, 32'h0000_100C);
		end
		issue(16'h0923, 32'h0000_1000, 1'b0);
		insn_valid <= 1'b0;
		flush <= 1'b1;
		@(posedge core_clk);
		#1;
		flush <= 1'b0;
		chk("flush hold", int_hold_q, 1'b0);
		issue(16'h0009, 32'h0000_1002, 1'b0);
		chk("flush load", pc_load_q, 1'b0);
	endtask
	// Reset in mid-pair must drop the owed slot and its redirect
	task t_rst;
		issue(16'hA010, 32'h0000_1000, 1'b0);
		insn_valid <= 1'b0;
		rst <= 1'b1;
		@(posedge core_clk);
		#1;
		chk("rst hold", int_hold_q, 1'b0);
		chk("rst pc", pc_value_q, 32'h0000_0000);
		rst <= 1'b0;
		@(posedge core_clk);
		#1;
		issue(16'h0009, 32'h0000_1002, 1'b0);
		chk("rst load", pc_load_q, 1'b0);
		chk("rst seq", pc_value_q, 32'h0000_1004);
	endtask
	initial begin
		{rst, insn_valid, t_flag, flush, insn, insn_addr} = '0;
		rst = 1'b1;
		repeat (8) @(posedge core_clk);
		chk("rst pc", pc_value_q, 32'h0000_0000);
		rst <= 1'b0;
		@(posedge core_clk);
		#1;
		t_cond();
		t_dly();
		t_ill();
		t_rst();
		idle();
		stop_test();
	end
	// Bound on the whole run in case a task hangs
	initial begin
		#400000;
		fails++;
		stop_test();
	end
endmodule
